// *** common/rioc_consts.svh ***
// Purpose: Constants for the residual instantaneous overcurrent trip block
// Assumes: 100 MHz clock, samples scaled so that 100 % equals RATED_CNT counts
// Notes:   Definitions only
`ifndef RIOC_CONSTS_SVH
`define RIOC_CONSTS_SVH

`define RIOC_START_DEF      12'd200
`define RIOC_START_MIN      12'd10
`define RIOC_START_MAX_STD  12'd1000
`define RIOC_START_MAX_EXT  12'd3000
`define RIOC_ONE_TENTH_DIV  32'd10
`define RIOC_PCT_FULL       48'd100
`define RIOC_DOUBLE_MUL     64'd2
`define RIOC_CLK_MHZ        100
`define RIOC_T_PEAK_MS      15
`define RIOC_T_FUND_MS      25
`define RIOC_T_PEAK_CYC     (`RIOC_T_PEAK_MS * 1000 * `RIOC_CLK_MHZ)
`define RIOC_T_FUND_CYC     (`RIOC_T_FUND_MS * 1000 * `RIOC_CLK_MHZ)

`endif

// *** common/rioc_pkg.sv ***
// Purpose: Types for the residual instantaneous overcurrent trip block
// Assumes: Constants come from rioc_consts.svh
// Notes:   None
package rioc_pkg;

    typedef enum logic [1:0] {
        RIOC_OP_OFF,
        RIOC_OP_PEAK,
        RIOC_OP_FUND
    } rioc_op_e;

    typedef struct packed {
        logic [31:0] peak;
        logic [31:0] fund;
        logic        valid;
    } rioc_meas_s;

    typedef struct packed {
        logic        trip;
        logic        ev_on;
        logic        ev_off;
        logic [11:0] start_eff;
    } rioc_state_s;

endpackage

// *** core/rioc_trip.sv ***
// Purpose: Residual instantaneous overcurrent general trip decision
// Assumes: Peak and fundamental RMS values arrive from the sampling front end each sample,
//          in the same clock domain, scaled so that rated current reads RATED_CNT
// Notes:   Start setting is a percentage of rated current; one decision per valid sample
`timescale 1ns/1ps
`default_nettype none
`include "rioc_consts.svh"

// What this block does
// - Selector off, peak or fundamental; off blocks
// - Upper limit 3000 with extended input
// - Block input suppresses the general trip
// - Doubling input compares against twice threshold
// - Single general trip output
// - On and off events on trip changes
// - Live general trip status readable
// - Instantaneous above one tenth rated current
// - Trip within 15 or 25 ms
// - Compare selected peak or fundamental value
module rioc_trip #(
    parameter int RATED_CNT = 1000
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire rioc_pkg::rioc_op_e operation,
    input  wire logic [11:0]        start_pct,
    input  wire logic               ext_range,
    input  wire logic               residual_block_in,
    input  wire logic               threshold_double_in,
    input  wire rioc_pkg::rioc_meas_s meas,
    output logic                    residual_general_trip_out,
    output logic                    trip_status,
    output logic                    event_on,
    output logic                    event_off
);

    // ************************************************************
    // Threshold arithmetic
    // ************************************************************
    // Out-of-range settings are pulled to the nearest limit rather than refused,
    // so a bad setting can never leave the function disarmed
    function automatic logic [11:0] clamp_start(input logic [11:0] s, input logic ext);
        logic [11:0] hi;
        hi = ext ? `RIOC_START_MAX_EXT : `RIOC_START_MAX_STD;
        if (s < `RIOC_START_MIN)
            clamp_start = `RIOC_START_MIN;
        else if (s > hi)
            clamp_start = hi;
        else
            clamp_start = s;
    endfunction

    // Percent times rated count over 100; wide enough for 2 x 3000 % of 32-bit scale
    function automatic logic [47:0] pct_to_cnt(input logic [12:0] pct);
        pct_to_cnt = (48'(pct) * 48'(RATED_CNT)) / `RIOC_PCT_FULL;
    endfunction

    rioc_pkg::rioc_state_s st_q;
    rioc_pkg::rioc_state_s st_d;
    logic [12:0]           pct_eff;
    logic [47:0]           thr_cnt;
    logic [31:0]           measured;
    logic                  above;

    always_comb begin
        pct_eff  = threshold_double_in ? {st_q.start_eff, 1'b0} : {1'b0, st_q.start_eff};
        thr_cnt  = pct_to_cnt(pct_eff);
        measured = (operation == rioc_pkg::RIOC_OP_PEAK) ? meas.peak : meas.fund;
        above    = (48'(measured) > thr_cnt);
    end

    // ************************************************************
    // Decision and events
    // ************************************************************
    always_comb begin
        st_d           = st_q;
        st_d.ev_on     = 1'b0;
        st_d.ev_off    = 1'b0;
        st_d.start_eff = clamp_start(start_pct, ext_range);
        // Block and mode take effect at once; no intentional delay anywhere
        // Between samples the decision is held, so a gap in the sample stream
        // cannot make the general trip chatter
        if (residual_block_in || operation == rioc_pkg::RIOC_OP_OFF) begin
            st_d.trip = 1'b0;
        end else if (meas.valid) begin
            st_d.trip = above;
        end
        st_d.ev_on  = st_d.trip & ~st_q.trip;
        st_d.ev_off = ~st_d.trip & st_q.trip;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= '{trip: 1'b0, ev_on: 1'b0, ev_off: 1'b0, start_eff: `RIOC_START_DEF};
        end else begin
            st_q <= st_d;
        end
    end

    assign residual_general_trip_out = st_q.trip;
    assign trip_status               = st_q.trip;
    assign event_on                  = st_q.ev_on;
    assign event_off                 = st_q.ev_off;

    // ************************************************************
    // Checks
    // ************************************************************
    // Reference comparison in cross-multiplied form, independent of the divided
    // threshold, so the checks catch a rounding or doubling slip in the datapath
    function automatic logic over_ref(input logic [31:0] val, input logic [11:0] start, input logic dbl);
        logic [63:0] lhs;
        logic [63:0] rhs;
        lhs = 64'(val) * 64'(`RIOC_PCT_FULL);
        rhs = 64'(start) * 64'(RATED_CNT);
        if (dbl)
            rhs = rhs * `RIOC_DOUBLE_MUL;
        over_ref = lhs > rhs;
    endfunction

    sequence s_rise;
        !residual_general_trip_out ##1 residual_general_trip_out;
    endsequence

    sequence s_fall;
        residual_general_trip_out ##1 !residual_general_trip_out;
    endsequence

    off_no_trip_a: assert property (@(posedge clk) disable iff (!rst_n)
        (operation == rioc_pkg::RIOC_OP_OFF) |=> !residual_general_trip_out)
        else $error("trip while operation off");

    block_no_trip_a: assert property (@(posedge clk) disable iff (!rst_n)
        residual_block_in |=> !residual_general_trip_out)
        else $error("trip while blocked");

    trip_on_over_a: assert property (@(posedge clk) disable iff (!rst_n)
        (meas.valid && above && !residual_block_in && operation != rioc_pkg::RIOC_OP_OFF)
        |=> residual_general_trip_out)
        else $error("no trip above threshold");

    trip_needs_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_rise |-> $past(meas.valid && above && !residual_block_in))
        else $error("trip rose without cause");

    event_on_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_rise |-> event_on && !event_off)
        else $error("missing on event");

    event_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_fall |-> event_off && !event_on)
        else $error("missing off event");

    status_match_a: assert property (@(posedge clk) disable iff (!rst_n)
        trip_status == residual_general_trip_out)
        else $error("status differs from trip");

    limit_range_a: assert property (@(posedge clk) disable iff (!rst_n)
        ##1 (st_q.start_eff <= `RIOC_START_MAX_EXT) && ($past(ext_range) || st_q.start_eff <= `RIOC_START_MAX_STD))
        else $error("start setting outside range");

    double_thr_a: assert property (@(posedge clk) disable iff (!rst_n)
        (threshold_double_in && meas.valid && !residual_block_in && operation == rioc_pkg::RIOC_OP_PEAK
         && !over_ref(meas.peak, st_q.start_eff, 1'b1))
        |=> !residual_general_trip_out)
        else $error("trip below doubled threshold");

    setting_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        st_q.start_eff >= `RIOC_START_MIN)
        else $error("start setting below lower limit");

    reset_clear_a: assert property (@(posedge clk)
        !rst_n |=> !residual_general_trip_out && !event_on && !event_off)
        else $error("outputs not cleared by reset");

    // ************************************************************
    // Checks on the selected quantity and on holding between samples
    // ************************************************************
    peak_select_a: assert property (@(posedge clk) disable iff (!rst_n)
        (meas.valid && !residual_block_in && operation == rioc_pkg::RIOC_OP_PEAK
         && over_ref(meas.peak, st_q.start_eff, threshold_double_in))
        |=> residual_general_trip_out)
        else $error("peak above setting did not trip");

    peak_below_a: assert property (@(posedge clk) disable iff (!rst_n)
        (meas.valid && operation == rioc_pkg::RIOC_OP_PEAK
         && !over_ref(meas.peak, st_q.start_eff, threshold_double_in))
        |=> !residual_general_trip_out)
        else $error("peak at or below setting tripped");

    fund_select_a: assert property (@(posedge clk) disable iff (!rst_n)
        (meas.valid && !residual_block_in && operation == rioc_pkg::RIOC_OP_FUND
         && over_ref(meas.fund, st_q.start_eff, threshold_double_in))
        |=> residual_general_trip_out)
        else $error("fundamental above setting did not trip");

    fund_below_a: assert property (@(posedge clk) disable iff (!rst_n)
        (meas.valid && operation == rioc_pkg::RIOC_OP_FUND
         && !over_ref(meas.fund, st_q.start_eff, threshold_double_in))
        |=> !residual_general_trip_out)
        else $error("fundamental at or below setting tripped");

    hold_no_sample_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!meas.valid && !residual_block_in && operation != rioc_pkg::RIOC_OP_OFF)
        |=> $stable(residual_general_trip_out))
        else $error("trip changed without a sample");

    // ************************************************************
    // Checks on events
    // ************************************************************
    events_exclusive_a: assert property (@(posedge clk) disable iff (!rst_n)
        !(event_on && event_off))
        else $error("on and off events together");

    event_on_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
        event_on |-> residual_general_trip_out && !$past(residual_general_trip_out))
        else $error("on event without trip rise");

    event_off_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
        event_off |-> !residual_general_trip_out && $past(residual_general_trip_out))
        else $error("off event without trip fall");

endmodule // rioc_trip

`default_nettype wire

// *** testbench/rioc_fe_model.sv ***
// Purpose: Residual current front end model
// Assumes: Peak and fundamental values are worked out by the bench
// Notes:   Values are inverted between samples
`timescale 1ns/1ps
`default_nettype none
// ****
// Model
// ****
module rioc_fe_model (
    input  wire logic        send,
    input  wire logic [31:0] pk,
    input  wire logic [31:0] fd,
    output var rioc_pkg::rioc_meas_s meas
);
    // Stale values must not look like a real sample
    assign meas = send ? {pk, fd, 1'b1} : {~pk, ~fd, 1'b0};
endmodule // rioc_fe_model
`default_nettype wire

// *** testbench/rioc_trip_tb.sv ***
// Purpose: Self-checking bench for the residual trip block
// Assumes: RATED_CNT of 100, so one count equals one percent
// Notes:   None
`timescale 1ns/1ps
`default_nettype none
// ****
// Bench
// ****
module rioc_trip_tb;
    logic clk = 0, rst_n = 0, ext = 0, blk = 0, blk_pin = 0, dbl = 0, send = 0, prev = 0;
    logic [11:0] pct = 12'h0c8;
    logic [31:0] pk = 0, fd = 0;
    rioc_pkg::rioc_op_e op = rioc_pkg::RIOC_OP_OFF;
    rioc_pkg::rioc_meas_s meas;
    logic trip, stat, ev_on, ev_off;
    int n_fail = 0, num_checks = 0;
    always #5 clk = ~clk;
    rioc_fe_model u_rioc_fe_model (.send(send), .pk(pk), .fd(fd), .meas(meas));
    rioc_trip #(.RATED_CNT(100)) u_rioc_trip (.clk(clk), .rst_n(rst_n), .operation(op),
        .start_pct(pct), .ext_range(ext), .residual_block_in(blk_pin), .threshold_double_in(dbl),
        .meas(meas), .residual_general_trip_out(trip), .trip_status(stat),
        .event_on(ev_on), .event_off(ev_off));
    task automatic chk(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t mismatch got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic smp(input rioc_pkg::rioc_op_e o, input int p, input int f, input logic exp);
        @(posedge clk) #1;
        op = o;
        pk = p;
        fd = f;
        send = 1;
        // Block acts without a sample, so it must move with the sample for the event to land here
        blk_pin = blk;
        @(posedge clk) #1;
        send = 0;
        chk(trip, exp);
        chk(stat, exp);
        chk(ev_on, exp & ~prev);
        chk(ev_off, ~exp & prev);
        prev = exp;
    endtask
    task automatic t_mode;
        smp(rioc_pkg::RIOC_OP_OFF, 900, 900, 0);
        smp(rioc_pkg::RIOC_OP_PEAK, 201, 0, 1);
        smp(rioc_pkg::RIOC_OP_PEAK, 200, 900, 0);
        smp(rioc_pkg::RIOC_OP_FUND, 900, 201, 1);
        smp(rioc_pkg::RIOC_OP_FUND, 201, 200, 0);
        $display("mode test done");
    endtask
    task automatic t_block;
        smp(rioc_pkg::RIOC_OP_PEAK, 500, 500, 1);
        blk = 1;
        smp(rioc_pkg::RIOC_OP_PEAK, 500, 500, 0);
        blk = 0;
        smp(rioc_pkg::RIOC_OP_PEAK, 500, 500, 1);
        smp(rioc_pkg::RIOC_OP_OFF, 500, 500, 0);
        $display("block test done");
    endtask
    task automatic t_double;
        dbl = 1;
        smp(rioc_pkg::RIOC_OP_PEAK, 400, 0, 0);
        smp(rioc_pkg::RIOC_OP_PEAK, 401, 0, 1);
        dbl = 0;
        $display("double test done");
    endtask
    task automatic t_range;
        pct = 12'hbb8;
        smp(rioc_pkg::RIOC_OP_PEAK, 1000, 0, 0);
        smp(rioc_pkg::RIOC_OP_PEAK, 1001, 0, 1);
        ext = 1;
        smp(rioc_pkg::RIOC_OP_PEAK, 3000, 0, 0);
        smp(rioc_pkg::RIOC_OP_PEAK, 3001, 0, 1);
        pct = 12'h005;
        smp(rioc_pkg::RIOC_OP_PEAK, 10, 0, 0);
        smp(rioc_pkg::RIOC_OP_PEAK, 11, 0, 1);
        $display("range test done");
    endtask
    task automatic complete_run;
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        #1 rst_n = 1;
        t_mode();
        t_block();
        t_double();
        t_range();
        complete_run();
    end
endmodule // rioc_trip_tb
`default_nettype wire
